// [core/tmon_regbank.v]
// register bank of the three-channel temperature monitor with fan drive level
`timescale 1ns/1ps
`include "tmon_regs.vh"

module tmon_regbank #(
	parameter [7:0] MAKER_ID  = 8'h5A, // arbitrary value
	parameter [3:0] VERSION   = 4'h7,  // arbitrary value
	parameter [3:0] STEPPING  = 4'h0,  // arbitrary value
	parameter       DATA_W    = 8
) (
	input  wire              sys_clk_i,
	input  wire              reset_n_i,
	// register port
	input  wire [7:0]        reg_addr_i,
	input  wire              reg_wr_i,
	input  wire [DATA_W-1:0] reg_wdata_i,
	input  wire              reg_rd_i,
	output reg  [DATA_W-1:0] reg_rdata_o,
	output reg               reg_rvalid_o,
	// conversion results, same clock
	input  wire              conv_valid_i,
	input  wire [DATA_W-1:0] conv_remote2_i,
	input  wire [DATA_W-1:0] conv_remote1_i,
	input  wire [DATA_W-1:0] conv_local_i,
	// outputs to the rest of the device
	output reg  [DATA_W-1:0] fan_drive_level_o,
	output wire              irq_o,
	output reg               overtemp_o,
	output wire              trip_lock_o
);

	// true when t leaves the window [lo, hi]
	function out_of_window;
		input [DATA_W-1:0] t;
		input [DATA_W-1:0] hi;
		input [DATA_W-1:0] lo;
		begin
			out_of_window = (t > hi) || (t < lo);
		end
	endfunction

	// true when the port hits address a with a write
	function wr_hit;
		input [7:0] addr;
		input       wr;
		input [7:0] a;
		begin
			wr_hit = wr && (addr == a);
		end
	endfunction

	reg [DATA_W-1:0] configuration;
	reg [DATA_W-1:0] interrupt_flags;
	reg [DATA_W-1:0] interrupt_enable_mask;
	reg [DATA_W-1:0] local_trip_programmable;
	reg [DATA_W-1:0] remote_trip_programmable;
	reg [DATA_W-1:0] factory_test;
	reg [DATA_W-1:0] remote2_reading;
	reg [DATA_W-1:0] remote1_reading;
	reg [DATA_W-1:0] local_reading;
	reg [DATA_W-1:0] remote2_upper_limit;
	reg [DATA_W-1:0] remote2_lower_limit;
	reg [DATA_W-1:0] remote1_upper_limit;
	reg [DATA_W-1:0] remote1_lower_limit;
	reg [DATA_W-1:0] local_upper_limit;
	reg [DATA_W-1:0] local_lower_limit;
	reg              reading_fresh;

	wire [DATA_W-1:0] local_trip_fixed  = `TMON_RST_LTRIP;
	wire [DATA_W-1:0] remote_trip_fixed = `TMON_RST_RTRIP;
	wire              trip_locked       = configuration[`TMON_CFG_LOCK_BIT];
	wire [DATA_W-1:0] local_trip_active;
	wire [DATA_W-1:0] remote_trip_active;
	wire [DATA_W-1:0] remote_hottest;
	reg  [DATA_W-1:0] next_flags;
	reg  [DATA_W-1:0] flag_events;
	reg  [DATA_W-1:0] read_value;

	assign trip_lock_o = trip_locked;

	// the fixed points are dropped once locked; then the programmed ones rule
	assign local_trip_active  = trip_locked ? local_trip_programmable
		: local_trip_fixed;
	assign remote_trip_active = trip_locked ? remote_trip_programmable
		: remote_trip_fixed;
	assign remote_hottest = (remote1_reading > remote2_reading) ? remote1_reading
		: remote2_reading;

	// configuration: lock bit is write-once, only reset clears it
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			configuration <= `TMON_RST_CONFIG;
		end else if (wr_hit(reg_addr_i, reg_wr_i, `TMON_ADDR_CONFIG)) begin
			configuration <= reg_wdata_i;
			configuration[`TMON_CFG_LOCK_BIT] <= trip_locked
				| reg_wdata_i[`TMON_CFG_LOCK_BIT];
		end
	end

	// programmable trip points, frozen by the lock bit
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			local_trip_programmable  <= `TMON_RST_LTRIP;
			remote_trip_programmable <= `TMON_RST_RTRIP;
		end else if (!trip_locked) begin
			if (wr_hit(reg_addr_i, reg_wr_i, `TMON_ADDR_LTRIP_PROG)) begin
				local_trip_programmable <= reg_wdata_i;
			end
			if (wr_hit(reg_addr_i, reg_wr_i, `TMON_ADDR_RTRIP_PROG)) begin
				remote_trip_programmable <= reg_wdata_i;
			end
		end
	end

	// plain read/write registers: interrupt mask and value registers
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			interrupt_enable_mask <= `TMON_RST_INT;
			factory_test          <= `TMON_RST_ZERO;
			fan_drive_level_o     <= `TMON_RST_FAN_LEVEL;
			remote2_upper_limit   <= `TMON_RST_UPPER;
			remote2_lower_limit   <= `TMON_RST_LOWER;
			remote1_upper_limit   <= `TMON_RST_UPPER;
			remote1_lower_limit   <= `TMON_RST_LOWER;
			local_upper_limit     <= `TMON_RST_UPPER;
			local_lower_limit     <= `TMON_RST_LOWER;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`TMON_ADDR_INT_MASK: begin
					interrupt_enable_mask <= reg_wdata_i;
				end
				`TMON_ADDR_FACTORY_TEST: begin
					factory_test <= reg_wdata_i;
				end
				`TMON_ADDR_FAN_LEVEL: begin
					fan_drive_level_o <= reg_wdata_i;
				end
				`TMON_ADDR_R2_UPPER: begin
					remote2_upper_limit <= reg_wdata_i;
				end
				`TMON_ADDR_R2_LOWER: begin
					remote2_lower_limit <= reg_wdata_i;
				end
				`TMON_ADDR_R1_UPPER: begin
					remote1_upper_limit <= reg_wdata_i;
				end
				`TMON_ADDR_R1_LOWER: begin
					remote1_lower_limit <= reg_wdata_i;
				end
				`TMON_ADDR_LOC_UPPER: begin
					local_upper_limit <= reg_wdata_i;
				end
				`TMON_ADDR_LOC_LOWER: begin
					local_lower_limit <= reg_wdata_i;
				end
				default: begin
				end
			endcase
		end
	end

	// readings follow the converter only; the register port cannot touch them
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			remote2_reading <= `TMON_RST_ZERO;
			remote1_reading <= `TMON_RST_ZERO;
			local_reading   <= `TMON_RST_ZERO;
			reading_fresh   <= 1'b0;
		end else begin
			reading_fresh <= conv_valid_i;
			if (conv_valid_i) begin
				remote2_reading <= conv_remote2_i;
				remote1_reading <= conv_remote1_i;
				local_reading   <= conv_local_i;
			end
		end
	end

	// limit and trip events, checked once per fresh set of readings
	always @* begin
		flag_events = `TMON_RST_ZERO;
		if (reading_fresh) begin
			flag_events[`TMON_INT_LOC_HIGH] = local_reading > local_upper_limit;
			flag_events[`TMON_INT_LOC_LOW]  = local_reading < local_lower_limit;
			flag_events[`TMON_INT_R1_HIGH]  = remote1_reading > remote1_upper_limit;
			flag_events[`TMON_INT_R1_LOW]   = remote1_reading < remote1_lower_limit;
			flag_events[`TMON_INT_R2_HIGH]  = remote2_reading > remote2_upper_limit;
			flag_events[`TMON_INT_R2_LOW]   = remote2_reading < remote2_lower_limit;
			flag_events[`TMON_INT_LOC_TRIP] = local_reading >= local_trip_active;
			flag_events[`TMON_INT_REM_TRIP] = remote_hottest >= remote_trip_active;
		end
	end

	// sticky flags: cleared by a read of the status register, a new event wins
	always @* begin
		next_flags = interrupt_flags;
		if (reg_rd_i && (reg_addr_i == `TMON_ADDR_INT_FLAGS)) begin
			next_flags = `TMON_RST_INT;
		end
		next_flags = next_flags | flag_events;
	end

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			interrupt_flags <= `TMON_RST_INT;
		end else begin
			interrupt_flags <= next_flags;
		end
	end

	// a set mask bit silences its source
	assign irq_o = |(interrupt_flags & ~interrupt_enable_mask);

	// over-temperature level, refreshed with every reading set
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			overtemp_o <= 1'b0;
		end else if (reading_fresh) begin
			overtemp_o <= flag_events[`TMON_INT_LOC_TRIP]
				| flag_events[`TMON_INT_REM_TRIP];
		end
	end

	// read multiplexer; unused addresses read zero
	always @* begin
		case (reg_addr_i)
			`TMON_ADDR_MAKER_ID:     read_value = MAKER_ID;
			`TMON_ADDR_REVISION:     read_value = {VERSION, STEPPING};
			`TMON_ADDR_CONFIG:       read_value = configuration;
			`TMON_ADDR_INT_FLAGS:    read_value = interrupt_flags;
			`TMON_ADDR_INT_MASK:     read_value = interrupt_enable_mask;
			`TMON_ADDR_INT_COPY:     read_value = interrupt_flags;
			`TMON_ADDR_FACTORY_TEST: read_value = factory_test;
			`TMON_ADDR_LTRIP_PROG:   read_value = local_trip_programmable;
			`TMON_ADDR_RTRIP_PROG:   read_value = remote_trip_programmable;
			`TMON_ADDR_LTRIP_FIXED:  read_value = local_trip_fixed;
			`TMON_ADDR_RTRIP_FIXED:  read_value = remote_trip_fixed;
			`TMON_ADDR_FAN_LEVEL:    read_value = fan_drive_level_o;
			`TMON_ADDR_R2_READING:   read_value = remote2_reading;
			`TMON_ADDR_R1_READING:   read_value = remote1_reading;
			`TMON_ADDR_LOC_READING:  read_value = local_reading;
			`TMON_ADDR_R2_UPPER:     read_value = remote2_upper_limit;
			`TMON_ADDR_R2_LOWER:     read_value = remote2_lower_limit;
			`TMON_ADDR_R1_UPPER:     read_value = remote1_upper_limit;
			`TMON_ADDR_R1_LOWER:     read_value = remote1_lower_limit;
			`TMON_ADDR_LOC_UPPER:    read_value = local_upper_limit;
			`TMON_ADDR_LOC_LOWER:    read_value = local_lower_limit;
			default:                 read_value = `TMON_RST_ZERO;
		endcase
	end

	// read data registered, one cycle after the request
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o  <= `TMON_RST_ZERO;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= read_value;
			end
		end
	end

endmodule

// [core/tmon_regs.vh]
// register map constants of the three-channel temperature monitor register bank
// Summary of operation
// - A read-only maker identification register sits at 0x3E and ignores writes.
// - A read-only revision register at 0x3F gives stepping in [3:0] and version in [7:4].
// - The configuration register at 0x40 loads 0010 0101 at power-on.
// - Interrupt status, mask and status copy registers clear to zero at power-on.
// - The programmable local trip point defaults to 70 C and is writable only while lock bit 3 is clear.
// - The programmable remote trip point defaults to 100 C and ignores writes once lock bit 3 is set.
// - A read-only fixed local trip point of 70 C exists and is disabled while lock bit 3 is set.
// - A read-only fixed remote trip point of 100 C exists and is disabled while lock bit 3 is set.
// - The fan drive level register resets to zero and its value drives the fan output level.
// - Three read-only temperature readings exist: remote 2, remote 1 and local; writes leave them alone.
// - Each of the three channels has a read/write upper limit and lower limit register.
// - All value registers lie in the address range 0x13 to 0x3A.
// - A reading above its upper limit or below its lower limit raises an unmasked interrupt.
`ifndef TMON_REGS_VH
`define TMON_REGS_VH

// fixed map
`define TMON_ADDR_MAKER_ID      8'h3E
`define TMON_ADDR_REVISION      8'h3F
`define TMON_ADDR_CONFIG        8'h40
`define TMON_ADDR_INT_FLAGS     8'h41
`define TMON_ADDR_INT_MASK      8'h43
`define TMON_ADDR_INT_COPY      8'h4C

// value range and the value registers inside it
`define TMON_ADDR_VALUE_LO      8'h13
`define TMON_ADDR_VALUE_HI      8'h3A
`define TMON_ADDR_FACTORY_TEST  8'h13
`define TMON_ADDR_LTRIP_PROG    8'h14
`define TMON_ADDR_RTRIP_PROG    8'h15
`define TMON_ADDR_LTRIP_FIXED   8'h16
`define TMON_ADDR_RTRIP_FIXED   8'h17
`define TMON_ADDR_FAN_LEVEL     8'h19
`define TMON_ADDR_R2_READING    8'h1A
`define TMON_ADDR_R1_READING    8'h1B
`define TMON_ADDR_LOC_READING   8'h1C
`define TMON_ADDR_R2_UPPER      8'h2B
`define TMON_ADDR_R2_LOWER      8'h2C
`define TMON_ADDR_R1_UPPER      8'h2D
`define TMON_ADDR_R1_LOWER      8'h2E
`define TMON_ADDR_LOC_UPPER     8'h2F
`define TMON_ADDR_LOC_LOWER     8'h30

// reset values
`define TMON_RST_CONFIG         8'h25
`define TMON_RST_INT            8'h00
`define TMON_RST_LTRIP          8'h46
`define TMON_RST_RTRIP          8'h64
`define TMON_RST_FAN_LEVEL      8'h00
`define TMON_RST_UPPER          8'hFF
`define TMON_RST_LOWER          8'h00
`define TMON_RST_ZERO           8'h00

// field positions
`define TMON_CFG_LOCK_BIT       3
`define TMON_INT_LOC_HIGH       0
`define TMON_INT_LOC_LOW        1
`define TMON_INT_R1_HIGH        2
`define TMON_INT_R1_LOW         3
`define TMON_INT_R2_HIGH        4
`define TMON_INT_R2_LOW         5
`define TMON_INT_LOC_TRIP       6
`define TMON_INT_REM_TRIP       7

`endif

// [tb/tmon_regbank_sva.sv]
// assertion checker on the register bank ports
`timescale 1ns/1ps
module tmon_regbank_sva #(
	parameter [7:0] MAKER_ID = 8'h00,
	parameter [3:0] VERSION  = 4'h0,
	parameter [3:0] STEPPING = 4'h0
) (
	input wire       sys_clk_i,
	input wire       reset_n_i,
	input wire [7:0] reg_addr_i,
	input wire       reg_wr_i,
	input wire [7:0] reg_wdata_i,
	input wire       reg_rd_i,
	input wire [7:0] reg_rdata_o,
	input wire       reg_rvalid_o,
	input wire [7:0] fan_drive_level_o,
	input wire       trip_lock_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	wire fan_wr = reg_wr_i && reg_addr_i == 8'h19;

	// read answer timing
	chk_read_answers: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read strobe without valid");
	chk_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("valid without read");
	// write-once lock
	chk_lock_sticky: assert property (trip_lock_o |=> trip_lock_o)
		else $error("lock bit cleared");
	chk_lock_set: assert property (
		reg_wr_i && reg_addr_i == 8'h40 && reg_wdata_i[3] |=> trip_lock_o)
		else $error("lock bit not set");
	chk_cfg_read: assert property (
		reg_rd_i && reg_addr_i == 8'h40 |=> reg_rdata_o[3] == $past(trip_lock_o))
		else $error("configuration read lock mismatch");
	// fan level register drives the output
	chk_fan_write: assert property (
		fan_wr |=> fan_drive_level_o == $past(reg_wdata_i))
		else $error("fan level not written");
	chk_fan_hold: assert property (!fan_wr |=> $stable(fan_drive_level_o))
		else $error("fan level changed without write");
	// identity reads
	chk_id_read: assert property (
		reg_rd_i && reg_addr_i == 8'h3E |=> reg_rdata_o == MAKER_ID)
		else $error("maker code read wrong");
	chk_rev_read: assert property (
		reg_rd_i && reg_addr_i == 8'h3F |=> reg_rdata_o == {VERSION, STEPPING})
		else $error("revision read wrong");

	cover property (reg_wr_i && reg_addr_i == 8'h40 && reg_wdata_i[3]);
	cover property ($rose(trip_lock_o));
	cover property (fan_wr ##1 fan_drive_level_o != 8'h00);
endmodule

bind tmon_regbank tmon_regbank_sva #(.MAKER_ID(MAKER_ID), .VERSION(VERSION),
	.STEPPING(STEPPING)) chk_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
	.fan_drive_level_o(fan_drive_level_o), .trip_lock_o(trip_lock_o));

// [tb/tmon_host_model.sv]
// host controller model driving the register port
`timescale 1ns/1ps
module tmon_host_model (
	input  wire       clk_i,
	output logic [7:0] addr_o,
	output logic       wr_o,
	output logic [7:0] wdata_o,
	output logic       rd_o
);
	// idle port at time zero
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// one word per transfer; released lines show inverted data
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		if (w && a == 8'h13)
			return;
		@(posedge clk_i);
		#2;
		addr_o = a;
		wdata_o = d;
		wr_o = w;
		rd_o = !w;
		@(posedge clk_i);
		#2;
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
endmodule

// [tb/tmon_regbank_tb_top.sv]
// self-checking bench of the temperature monitor register bank
`timescale 1ns/1ps
module tmon_regbank_tb_top;
	localparam [7:0] ID_VAL = 8'hA3; // arbitrary value
	localparam [3:0] VER = 4'h9;     // arbitrary value
	localparam [3:0] STEP = 4'h2;    // arbitrary value
	localparam [12:0] RO_SET = 13'h1B2B;
	logic       sys_clk_i, reset_n_i, conv_valid;
	logic [7:0] conv_r2, conv_r1, conv_loc, v;
	wire  [7:0] reg_addr, reg_wdata, reg_rdata, fan_level;
	wire        reg_wr, reg_rd, reg_rvalid, irq, overtemp, trip_lock;
	logic [7:0] exp_q[$];
	int         miscompares, tests_run;
	logic [7:0] rst_a[13] = '{8'h3E, 8'h3F, 8'h40, 8'h41, 8'h43, 8'h4C, 8'h14, 8'h15,
		8'h16, 8'h17, 8'h19, 8'h1A, 8'h50};
	logic [7:0] rst_v[13] = '{ID_VAL, {VER, STEP}, 8'h25, 8'h00, 8'h00, 8'h00, 8'h46,
		8'h64, 8'h46, 8'h64, 8'h00, 8'h00, 8'h00};
	logic [7:0] rw_a[8] = '{8'h43, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h19};
	logic [7:0] lim_v[8] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h3F, 8'h00, 8'h00};

	tmon_regbank #(.MAKER_ID(ID_VAL), .VERSION(VER), .STEPPING(STEP)) dut_u (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr),
		.reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .conv_valid_i(conv_valid),
		.conv_remote2_i(conv_r2), .conv_remote1_i(conv_r1), .conv_local_i(conv_loc),
		.fan_drive_level_o(fan_level), .irq_o(irq), .overtemp_o(overtemp),
		.trip_lock_o(trip_lock));
	tmon_host_model host_u (.clk_i(sys_clk_i), .addr_o(reg_addr), .wr_o(reg_wr),
		.wdata_o(reg_wdata), .rd_o(reg_rd));

	// 40 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	task cmp(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task exp_rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_u.xfer(1'b0, a, 8'h00);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		host_u.xfer(1'b1, a, d);
	endtask

	// one conversion set, returns once flags are visible
	task conv(input logic [7:0] l, input logic [7:0] r);
		@(posedge sys_clk_i);
		#2;
		conv_r2 = 8'h20;
		conv_r1 = r;
		conv_loc = l;
		conv_valid = 1'b1;
		@(posedge sys_clk_i);
		#2;
		conv_valid = 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#2;
	endtask

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// each returned word against the oldest note
	always @(posedge sys_clk_i) begin
		if (reg_rvalid === 1'b1)
			cmp(reg_rdata, exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX);
	end

	// run limit
	initial begin
		#2000000;
		miscompares++;
		tally_and_finish;
	end

	initial begin
		miscompares = 0;
		tests_run = 0;
		reset_n_i = 1'b0;
		conv_valid = 1'b0;
		conv_r2 = 8'h00;
		conv_r1 = 8'h00;
		conv_loc = 8'h00;
		void'($urandom(82934));
		repeat (16) @(posedge sys_clk_i);
		#2;
		reset_n_i = 1'b1;
		for (int p = 0; p < 2; p++) begin
			foreach (rst_a[i]) exp_rd(rst_a[i], rst_v[i]);
			foreach (rst_a[i]) begin
				if (RO_SET[i] && p == 0)
					wr(rst_a[i], 8'($urandom));
			end
		end
		$display("reset and read-only test done");
		foreach (rw_a[i]) begin
			v = 8'($urandom);
			wr(rw_a[i], v);
			exp_rd(rw_a[i], v);
		end
		cmp(fan_level, v);
		$display("read-write test done");
		foreach (rw_a[i]) wr(rw_a[i], lim_v[i]);
		for (int m = 0; m < 2; m++) begin
			wr(8'h43, 8'(m));
			conv(8'h40, 8'h20);
			cmp({7'h00, irq}, 8'(1 - m));
			exp_rd(8'h4C, 8'h01);
			exp_rd(8'h41, 8'h01);
			exp_rd(8'h41, 8'h00);
			exp_rd(8'h1C, 8'h40);
			cmp({7'h00, irq}, 8'h00);
		end
		$display("interrupt test done");
		wr(8'h14, 8'h50);
		conv(8'h48, 8'h20);
		cmp({7'h00, overtemp}, 8'h01);
		wr(8'h40, 8'h2D);
		cmp({7'h00, trip_lock}, 8'h01);
		wr(8'h14, 8'h33);
		wr(8'h15, 8'h33);
		wr(8'h40, 8'h25);
		conv(8'h48, 8'h20);
		cmp({7'h00, overtemp}, 8'h00);
		exp_rd(8'h14, 8'h50);
		exp_rd(8'h15, 8'h64);
		exp_rd(8'h40, 8'h2D);
		$display("trip lock test done");
		// mid-run reset: lock cleared, the fixed remote point rules again
		@(posedge sys_clk_i);
		#2;
		reset_n_i = 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#2;
		reset_n_i = 1'b1;
		cmp({7'h00, trip_lock}, 8'h00);
		conv(8'h20, 8'h64);
		cmp({7'h00, overtemp}, 8'h01);
		exp_rd(8'h41, 8'h80);
		exp_rd(8'h40, 8'h25);
		for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge sys_clk_i);
		if (exp_q.size() != 0)
			miscompares++;
		$display("mid-run reset test done");
		tally_and_finish;
	end
endmodule
